// ### rdc_pkg.sv
package rdc_pkg;

  // Data path widths.
  localparam int DATA_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int ADDR_W   = 4;
  localparam int UPPER_W  = 4;
  localparam int EXC_W    = 8;
  localparam int CNT_W    = 5;
  localparam int STAT_W   = 4;

  // Register offsets on the internal register port.
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_EXC_FREQ = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_MASK     = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_POSITION = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_VELOCITY = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_HOSTBYTE = 4'h6;

  // Field positions.
  localparam int CTRL_EXC_EN = 0;
  localparam int ST_HOST_WR  = 0;
  localparam int ST_HOST_RD  = 1;
  localparam int ST_LOT      = 2;
  localparam int ST_DOS      = 3;

  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0001;
  localparam logic [EXC_W-1:0]  EXC_RESET  = 8'h3F;
  localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;

  // Serial frame sizes.
  localparam logic [CNT_W-1:0] SER_IN_BITS = 5'h08;
  localparam logic [CNT_W-1:0] SER_MAX     = 5'h10;

  // Operating mode chosen by the two mode pins.
  typedef enum logic [1:0] {
    MODE_POSITION = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_VELOCITY = 2'h2,
    MODE_CONFIG   = 2'h3
  } mode_t;

  // Serial frame tracker, one-hot.
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b001,
    FR_SHIFT = 3'b010,
    FR_END   = 3'b100
  } frame_state_t;

  // Control pins from the host, carried as one bundle.
  typedef struct packed {
    logic              chip_select_n;
    logic              read_strobe_n;
    logic              write_frame_strobe_n;
    logic              serial_clock;
    logic              serial_in;
    logic              interface_select;
    logic              mode_select_hi;
    logic              mode_select_lo;
    logic              reset_n;
    logic [BYTE_W-1:0] low_byte;
  } host_pins_t;

  localparam int PINS_W = $bits(host_pins_t);

endpackage : rdc_pkg

// ### pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser with edge pulses taken from the settled stage.
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock.
  input  wire logic         rst,   // Synchronous reset, active high.
  input  wire logic         ce,    // Clock enable.
  input  wire logic [W-1:0] d,     // Asynchronous inputs.
  output logic      [W-1:0] q,     // Synchronised level.
  output logic      [W-1:0] rise,  // One-cycle rising pulse.
  output logic      [W-1:0] fall   // One-cycle falling pulse.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // The first stage feeds only the second, so metastability stays boxed.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges compare the settled stage with its delayed copy.
  assign q    = sync_q;
  assign rise = sync_q & ~prev_q & {W{ce}};
  assign fall = ~sync_q & prev_q & {W{ce}};

endmodule : pin_sync

// ### enc_emul.sv
`timescale 1ns/1ps
// Quadrature, marker and direction outputs derived from the tracked angle.
module enc_emul
  import rdc_pkg::*;
(
  input  wire logic              clk,     // System clock.
  input  wire logic              rst,     // Synchronous reset, active high.
  input  wire logic              ce,      // Clock enable.
  input  wire logic [DATA_W-1:0] angle,   // Tracked angle.
  output logic                   quad_a,  // Encoder channel A.
  output logic                   quad_b,  // Encoder channel B.
  output logic                   north,   // North marker.
  output logic                   dir      // High while angle increases.
);

  logic [DATA_W-1:0] prev_q;
  logic [DATA_W-1:0] step;

  // Free running, no host action; the levels only mean something while
  // the resolver signals feeding the loop are valid.
  // free running outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      quad_a <= 1'b0;
      quad_b <= 1'b0;
      north  <= 1'b0;
      prev_q <= '0;
    end else if (ce) begin
      quad_a <= angle[1];
      quad_b <= angle[1] ^ angle[0];
      north  <= (angle[DATA_W-1:2] == '0);
      prev_q <= angle;
    end
  end

  // Modular step from the last angle; its sign bit marks a backward move,
  // so a wrap through zero still reads as the short way round.
  assign step = angle - prev_q;

  // The signed step gives the sense; a still angle keeps the last sense.
  // rotation sense
  always_ff @(posedge clk) begin
    if (rst) begin
      dir <= 1'b0;
    end else if (ce && angle != prev_q) begin
      dir <= ~step[DATA_W-1];
    end
  end

endmodule : enc_emul

// ### resolver_host_port_pins.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module resolver_host_port_pins
  import rdc_pkg::*;
(
  input  wire logic               clk,               // System clock.
  input  wire logic               rst,               // Sync reset, high.
  input  wire logic               ce,                // Clock enable.
  input  wire logic               reset_n,           // Device reset pin.
  input  wire logic               chip_select_n,     // Chip select pin.
  input  wire logic               read_strobe_n,     // Read strobe pin.
  input  wire logic               write_frame_strobe_n, // Write or frame.
  input  wire logic               interface_select,  // High parallel.
  input  wire logic               mode_select_hi,    // Mode pin, upper.
  input  wire logic               mode_select_lo,    // Mode pin, lower.
  output logic                    bit15_out,         // Bit 15 or serial out.
  output logic                    bit15_oe_n,        // Low while driven.
  input  wire logic               bit14_serial_in,   // Pin level read back.
  output logic                    bit14_out,         // Bit 14 drive value.
  output logic                    bit14_oe_n,        // Low while driven.
  input  wire logic               bit13_serial_clock, // Pin level read back.
  output logic                    bit13_out,         // Bit 13 drive value.
  output logic                    bit13_oe_n,        // Low while driven.
  output logic [UPPER_W-1:0]      upper_data_bits,   // Bits 12 to 9.
  output logic                    upper_oe_n,        // Low while driven.
  output logic                    data_bit_eight,    // Bit 8.
  output logic                    bit8_oe_n,         // Low while driven.
  input  wire logic [BYTE_W-1:0]  low_data_byte_in,  // Low byte pin levels.
  output logic [BYTE_W-1:0]       low_data_byte_out, // Low byte drive.
  output logic                    low_oe_n,          // Low while driven.
  output logic                    quad_a,            // Encoder A.
  output logic                    quad_b,            // Encoder B.
  output logic                    north_marker,      // Marker pulse.
  output logic                    rotation_sense,    // Direction.
  output logic                    tracking_loss_n,   // Loss of tracking.
  output logic                    signal_degraded_n, // Signal degraded.
  output logic                    drive_wave_out,    // Excitation.
  output logic                    drive_wave_out_n,  // Its complement.
  input  wire logic [DATA_W-1:0]  position_in,       // Loop angle.
  input  wire logic [DATA_W-1:0]  velocity_in,       // Loop velocity.
  input  wire logic               loss_in,           // Tracking lost.
  input  wire logic               over_threshold_in, // Sine or cosine high.
  input  wire logic               mismatch_in,       // Amplitude mismatch.
  input  wire logic [ADDR_W-1:0]  reg_addr,          // Register address.
  input  wire logic [DATA_W-1:0]  reg_wdata,         // Write data.
  input  wire logic               reg_we,            // Write strobe.
  input  wire logic               reg_re,            // Read strobe.
  output logic [DATA_W-1:0]       reg_rdata,         // Read data, next cycle.
  output logic                    irq                // Level interrupt.
);

  host_pins_t        pins_raw;
  host_pins_t        pins_s;
  host_pins_t        pins_rise;
  host_pins_t        pins_fall;
  logic              rst_all;
  logic              parallel;
  logic              rd_active;
  logic              wr_active;
  logic              frame_on;
  logic              rd_start;
  logic              wr_end;
  mode_t             mode;
  logic [DATA_W-1:0] word_q;
  logic [DATA_W-1:0] shift_q;
  logic [BYTE_W-1:0] shin_q;
  logic [CNT_W-1:0]  bit_cnt_q;
  logic [BYTE_W-1:0] host_byte_q;
  logic [DATA_W-1:0] ctrl_q;
  logic [EXC_W-1:0]  exc_q;
  logic [EXC_W-1:0]  exc_cnt_q;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] mask_q;
  logic [STAT_W-1:0] events;
  logic              frame_prev_q;
  frame_state_t      fr_q;

  // True while both active-low strobes of a pair are low.
  function automatic logic both_low(input logic a_n, input logic b_n);
    return ~a_n & ~b_n;
  endfunction : both_low

  // Every pin from the host crosses into the clock domain here.
  assign pins_raw = '{chip_select_n: chip_select_n,
                      read_strobe_n: read_strobe_n,
                      write_frame_strobe_n: write_frame_strobe_n,
                      serial_clock: bit13_serial_clock,
                      serial_in: bit14_serial_in,
                      interface_select: interface_select,
                      mode_select_hi: mode_select_hi,
                      mode_select_lo: mode_select_lo,
                      reset_n: reset_n,
                      low_byte: low_data_byte_in};

  pin_sync #(.W(PINS_W)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .d    (pins_raw),
    .q    (pins_s),
    .rise (pins_rise),
    .fall (pins_fall)
  );

  // The device pin reset is honoured once it has been synchronised.
  assign rst_all   = rst | ~pins_s.reset_n;
  assign parallel  = pins_s.interface_select;
  assign rd_active = parallel &
                     both_low(pins_s.chip_select_n, pins_s.read_strobe_n);
  assign wr_active = parallel &
                     both_low(pins_s.chip_select_n,
                              pins_s.write_frame_strobe_n);
  assign frame_on  = ~parallel &
                     both_low(pins_s.chip_select_n,
                              pins_s.write_frame_strobe_n);
  assign mode      = mode_t'({pins_s.mode_select_hi, pins_s.mode_select_lo});

  // Start of a read and end of a write, each a single-cycle pulse.
  logic rd_prev_q;
  logic wr_prev_q;
  always_ff @(posedge clk) begin
    if (rst_all) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else if (ce) begin
      rd_prev_q <= rd_active;
      wr_prev_q <= wr_active;
    end
  end
  assign rd_start = ce & rd_active & ~rd_prev_q;
  assign wr_end   = ce & ~wr_active & wr_prev_q;

  // The outgoing word is frozen at the start of each access, so a loop
  // update mid-read cannot tear the value the host sees.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      word_q <= '0;
    end else if (rd_start || (ce && frame_on && !frame_prev_q)) begin
      case (mode)
        MODE_VELOCITY: word_q <= velocity_in;
        MODE_CONFIG:   word_q <= {{(DATA_W-BYTE_W){1'b0}}, host_byte_q};
        default:       word_q <= position_in;
      endcase
    end
  end

  // Parallel output enables follow chip select and read.
  // bit 14 gating
  assign bit14_oe_n = ~rd_active;
  assign bit14_out  = word_q[14];
  assign bit13_oe_n = ~rd_active;
  assign bit13_out  = word_q[13];
  assign upper_oe_n      = ~rd_active;
  assign upper_data_bits = word_q[12:9];
  assign bit8_oe_n       = ~rd_active;
  assign data_bit_eight  = word_q[8];
  assign low_oe_n          = ~rd_active;
  assign low_data_byte_out = word_q[BYTE_W-1:0];
  // Bit 15 serves the read in parallel mode and the frame in serial mode.
  assign bit15_oe_n = ~(rd_active | frame_on);
  assign bit15_out  = parallel ? word_q[15] : shift_q[DATA_W-1];

  // Serial frame tracker; a frame that ends closes any partial shift.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      fr_q         <= FR_IDLE;
      frame_prev_q <= 1'b0;
    end else if (ce) begin
      frame_prev_q <= frame_on;
      case (fr_q)
        FR_IDLE:  if (frame_on) fr_q <= FR_SHIFT;
        FR_SHIFT: if (!frame_on) fr_q <= FR_END;
        FR_END:   fr_q <= FR_IDLE;
        default:  fr_q <= FR_IDLE;
      endcase
    end
  end

  // Outgoing bits advance on the serial clock rise, MSB first.
  // shift out on rise
  always_ff @(posedge clk) begin
    if (rst_all) begin
      shift_q <= '0;
    end else if (ce && frame_on && !frame_prev_q) begin
      case (mode)
        MODE_VELOCITY: shift_q <= velocity_in;
        MODE_CONFIG:   shift_q <= {{(DATA_W-BYTE_W){1'b0}}, host_byte_q};
        default:       shift_q <= position_in;
      endcase
    end else if (frame_on && pins_rise.serial_clock) begin
      shift_q <= {shift_q[DATA_W-2:0], 1'b0};
    end
  end

  // Incoming bits are taken on the serial clock fall, inside a frame only.
  // sample on fall
  always_ff @(posedge clk) begin
    if (rst_all) begin
      shin_q    <= '0;
      bit_cnt_q <= '0;
    end else if (ce && !frame_on) begin
      bit_cnt_q <= '0;
    end else if (frame_on && pins_fall.serial_clock) begin
      shin_q <= {shin_q[BYTE_W-2:0], pins_s.serial_in};
      if (bit_cnt_q != SER_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Host data lands at the end of a parallel write or of a serial frame of eight or more bits.
  // low byte write capture
  always_ff @(posedge clk) begin
    if (rst_all) begin
      host_byte_q <= '0;
    end else if (wr_end) begin
      host_byte_q <= pins_s.low_byte;
    end else if (ce && fr_q == FR_SHIFT && !frame_on &&
                 bit_cnt_q >= SER_IN_BITS) begin
      host_byte_q <= shin_q;
    end
  end

  // Fault pins are plain registered levels, never latched.
  // tracking loss level
  always_ff @(posedge clk) begin
    if (rst_all) begin
      tracking_loss_n   <= 1'b1;
      signal_degraded_n <= 1'b1;
    end else if (ce) begin
      tracking_loss_n   <= ~loss_in;
      signal_degraded_n <= ~(over_threshold_in | mismatch_in);
    end
  end

  enc_emul u_enc (
    .clk    (clk),
    .rst    (rst_all),
    .ce     (ce),
    .angle  (position_in),
    .quad_a (quad_a),
    .quad_b (quad_b),
    .north  (north_marker),
    .dir    (rotation_sense)
  );

  // Excitation pair: half period is the register value plus one cycles.
  // programmable frequency
  always_ff @(posedge clk) begin
    if (rst_all) begin
      exc_cnt_q      <= '0;
      drive_wave_out <= 1'b0;
    end else if (ce && !ctrl_q[CTRL_EXC_EN]) begin
      exc_cnt_q      <= '0;
      drive_wave_out <= 1'b0;
    end else if (ce && exc_cnt_q >= exc_q) begin
      exc_cnt_q      <= '0;
      drive_wave_out <= ~drive_wave_out;
    end else if (ce) begin
      exc_cnt_q <= exc_cnt_q + 8'h01;
    end
  end
  assign drive_wave_out_n = ~drive_wave_out;

  // Register writes; unmapped addresses are ignored.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ctrl_q <= CTRL_RESET;
      exc_q  <= EXC_RESET;
      mask_q <= MASK_RESET;
    end else if (ce && reg_we) begin
      case (reg_addr)
        ADDR_CTRL:     ctrl_q <= reg_wdata;
        ADDR_EXC_FREQ: exc_q  <= reg_wdata[EXC_W-1:0];
        ADDR_MASK:     mask_q <= reg_wdata[STAT_W-1:0];
        default:       ;
      endcase
    end
  end

  // Sticky events; a new event in the clearing read's cycle survives.
  assign events = {~signal_degraded_n, ~tracking_loss_n, rd_start, wr_end};
  always_ff @(posedge clk) begin
    if (rst_all) begin
      status_q <= '0;
    end else if (ce) begin
      if (reg_re && reg_addr == ADDR_STATUS) begin
        status_q <= events;
      end else begin
        status_q <= status_q | events;
      end
    end
  end
  assign irq = |(status_q & mask_q);

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clk) begin
    if (rst_all) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_re) begin
        case (reg_addr)
          ADDR_CTRL:     reg_rdata <= ctrl_q;
          ADDR_EXC_FREQ: reg_rdata <= {{(DATA_W-EXC_W){1'b0}}, exc_q};
          ADDR_STATUS:   reg_rdata <= {{(DATA_W-STAT_W){1'b0}}, status_q};
          ADDR_MASK:     reg_rdata <= {{(DATA_W-STAT_W){1'b0}}, mask_q};
          ADDR_POSITION: reg_rdata <= position_in;
          ADDR_VELOCITY: reg_rdata <= velocity_in;
          ADDR_HOSTBYTE: reg_rdata <= {{(DATA_W-BYTE_W){1'b0}}, host_byte_q};
          default:       reg_rdata <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_all);

  property p_bit14_gate;
    !rd_active |-> bit14_oe_n;
  endproperty
  a_bit14_gate: assert property (p_bit14_gate)
    else $error("bit 14 driven outside a read");

  sequence s_fall_in_frame;
    frame_on && pins_fall.serial_clock;
  endsequence
  property p_sample_fall;
    s_fall_in_frame |=> shin_q[0] == $past(pins_s.serial_in);
  endproperty
  a_sample_fall: assert property (p_sample_fall)
    else $error("serial input bit not sampled on clock fall");

  property p_bit13_serial;
    !parallel |-> bit13_oe_n && bit14_oe_n;
  endproperty
  a_bit13_serial: assert property (p_bit13_serial)
    else $error("serial clock or input pin driven in serial mode");

  property p_upper_gate;
    rd_active |-> !upper_oe_n && !bit8_oe_n && !bit15_oe_n;
  endproperty
  a_upper_gate: assert property (p_upper_gate)
    else $error("upper bits not driven during a read");

  property p_write_no_drive;
    wr_active |-> low_oe_n ##1 (wr_active || low_oe_n);
  endproperty
  a_write_no_drive: assert property (p_write_no_drive)
    else $error("low byte driven during a host write");

  property p_loss_follow;
    ce |=> tracking_loss_n == !$past(loss_in);
  endproperty
  a_loss_follow: assert property (p_loss_follow)
    else $error("tracking loss output does not follow condition");

  property p_degrade;
    ce && (mismatch_in || over_threshold_in) |=> !signal_degraded_n;
  endproperty
  a_degrade: assert property (p_degrade)
    else $error("degradation output not low on fault");

  property p_exc_toggle;
    ce && ctrl_q[CTRL_EXC_EN] && exc_cnt_q >= exc_q
      |=> drive_wave_out != $past(drive_wave_out) && exc_cnt_q == '0;
  endproperty
  a_exc_toggle: assert property (p_exc_toggle)
    else $error("excitation did not toggle at programmed count");

  sequence s_rise_in_frame;
    frame_on && frame_prev_q && pins_rise.serial_clock;
  endsequence
  property p_shift_rise;
    s_rise_in_frame |=> bit15_out == $past(shift_q[DATA_W-2]);
  endproperty
  a_shift_rise: assert property (p_shift_rise)
    else $error("serial output did not advance on clock rise");

  property p_idle_no_count;
    ce && !frame_on |=> bit_cnt_q == '0;
  endproperty
  a_idle_no_count: assert property (p_idle_no_count)
    else $error("serial bits counted outside a frame");

endmodule : resolver_host_port_pins

// ### host_model.sv
`timescale 1ns/1ps
// Host controller: parallel strobes and a serial frame master.
module host_model (
  input  wire logic        clk,                  // System clock.
  input  wire logic [15:0] bus,                  // Resolved data pins.
  output logic             chip_select_n,        // Chip select.
  output logic             read_strobe_n,        // Read strobe.
  output logic             write_frame_strobe_n, // Write or frame strobe.
  output logic             interface_select,     // High for parallel.
  output logic             host_sclk,            // Serial clock.
  output logic             host_sdi,             // Serial data in.
  output logic             drv_n,                // Low while byte driven.
  output logic [7:0]       host_byte             // Byte the host drives.
);
  // Idle state; the serial clock parks high so a frame opens with a fall.
  initial begin
    {chip_select_n, read_strobe_n, write_frame_strobe_n} = 3'h7;
    {interface_select, host_sclk, host_sdi, drv_n} = 4'hF;
    host_byte = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic par_rd(output logic [15:0] w);
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    cyc(7);
    w = bus;
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    cyc(4);
  endtask : par_rd
  task automatic par_wr(input logic [7:0] b);
    host_byte <= b;
    drv_n <= 1'b0;
    chip_select_n <= 1'b0;
    write_frame_strobe_n <= 1'b0;
    cyc(6);
    chip_select_n <= 1'b1;
    write_frame_strobe_n <= 1'b1;
    cyc(4);
    drv_n <= 1'b1;
    cyc(2);
  endtask : par_wr
  task automatic ser(input logic [15:0] v, output logic [15:0] w);
    interface_select <= 1'b0;
    cyc(4);
    chip_select_n <= 1'b0;
    write_frame_strobe_n <= 1'b0;
    cyc(8);
    for (int i = 15; i >= 0; i--) begin
      host_sdi <= v[i];
      cyc(4);
      w[i] = bus[15];
      host_sclk <= 1'b0;
      cyc(4);
      host_sclk <= 1'b1;
    end
    cyc(8);
    chip_select_n <= 1'b1;
    write_frame_strobe_n <= 1'b1;
    cyc(6);
    interface_select <= 1'b1;
    cyc(4);
  endtask : ser
endmodule : host_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import rdc_pkg::*;
  logic clk = 0, rst = 1, ce = 1, reset_n = 0, reg_we = 0, reg_re = 0;
  logic loss_in = 0, over_threshold_in = 0, mismatch_in = 0;
  logic mode_select_hi = 0, mode_select_lo = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, position_in = 16'h0000;
  logic [15:0] velocity_in = 16'h0000, w, bus, reg_rdata;
  logic chip_select_n, read_strobe_n, write_frame_strobe_n, interface_select;
  logic host_sclk, host_sdi, drv_n, bit14_serial_in, bit13_serial_clock;
  logic bit15_out, bit15_oe_n, bit14_out, bit14_oe_n, bit13_out, bit13_oe_n;
  logic upper_oe_n, data_bit_eight, bit8_oe_n, low_oe_n, quad_a, quad_b;
  logic north_marker, rotation_sense, tracking_loss_n, signal_degraded_n;
  logic drive_wave_out, drive_wave_out_n, irq;
  logic [7:0] host_byte, low_data_byte_in, low_data_byte_out;
  logic [3:0] upper_data_bits;
  int err_total = 0, samples_checked = 0, n;
  // Released lines show the inverse so stale data cannot pass.
  assign bit14_serial_in = !bit14_oe_n ? bit14_out
                         : (interface_select ? ~bit14_out : host_sdi);
  assign bit13_serial_clock = !bit13_oe_n ? bit13_out
                            : (interface_select ? ~bit13_out : host_sclk);
  assign low_data_byte_in = !low_oe_n ? low_data_byte_out
                          : (!drv_n ? host_byte : ~host_byte);
  assign bus = {bit15_oe_n ^ bit15_out, bit14_serial_in, bit13_serial_clock,
                {4{upper_oe_n}} ^ upper_data_bits, bit8_oe_n ^ data_bit_eight,
                low_data_byte_in};
  resolver_host_port_pins DUT (.clk, .rst, .ce, .reset_n, .chip_select_n,
    .read_strobe_n, .write_frame_strobe_n, .interface_select, .mode_select_hi,
    .mode_select_lo, .bit15_out, .bit15_oe_n, .bit14_serial_in, .bit14_out,
    .bit14_oe_n, .bit13_serial_clock, .bit13_out, .bit13_oe_n,
    .upper_data_bits, .upper_oe_n, .data_bit_eight, .bit8_oe_n,
    .low_data_byte_in, .low_data_byte_out, .low_oe_n, .quad_a, .quad_b,
    .north_marker, .rotation_sense, .tracking_loss_n, .signal_degraded_n,
    .drive_wave_out, .drive_wave_out_n, .position_in, .velocity_in, .loss_in,
    .over_threshold_in, .mismatch_in, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .irq);
  host_model HOST (.clk, .bus, .chip_select_n, .read_strobe_n,
    .write_frame_strobe_n, .interface_select, .host_sclk, .host_sdi, .drv_n,
    .host_byte);
  // Free-running 25 MHz clock.
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic rw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : rw
  task automatic rr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_re} <= {a, 1'b1};
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : rr
  // Bounded wait for the next excitation edge; a hang shows as a bad count.
  task automatic half(output int c);
    logic v;
    c = 0;
    v = drive_wave_out;
    while (drive_wave_out === v && c < 300) begin
      @(posedge clk);
      #1 c++;
    end
  endtask : half
  // Watchdog against a stuck sequence.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reset_n <= 1'b1;
    // The pin synchroniser holds the block in reset two more edges.
    repeat (2) @(posedge clk);
    rr(ADDR_CTRL, w); chk("ctrl", w, CTRL_RESET);
    rr(ADDR_EXC_FREQ, w); chk("exc", w, {8'h00, EXC_RESET});
    rr(ADDR_MASK, w); chk("mask", w, {12'h000, MASK_RESET});
    rr(4'hF, w); chk("unmapped", w, 16'h0000);
    position_in <= 16'hA5C3;
    velocity_in <= 16'h5AF0;
    HOST.par_rd(w); chk("par_pos", w, 16'hA5C3);
    chk("oe_idle", {10'h000, bit15_oe_n, bit14_oe_n, bit13_oe_n, upper_oe_n,
        bit8_oe_n, low_oe_n}, 16'h003F);
    // A jump past half a turn is the short way back round the circle.
    chk("dir_dn", {15'h0, rotation_sense}, 16'h0000);
    position_in <= 16'h0002;
    repeat (4) @(posedge clk);
    chk("dir_up", {15'h0, rotation_sense}, 16'h0001);
    chk("north", {15'h0, north_marker}, 16'h0001);
    chk("quad", {14'h0, quad_a, quad_b}, 16'h0003);
    {mode_select_hi, mode_select_lo} <= 2'h1;
    HOST.par_rd(w); chk("mode1", w, 16'h0002);
    {mode_select_hi, mode_select_lo} <= 2'h2;
    HOST.par_rd(w); chk("mode2", w, 16'h5AF0);
    HOST.par_wr(8'h96);
    rr(ADDR_HOSTBYTE, w); chk("host_byte", w, 16'h0096);
    {mode_select_hi, mode_select_lo} <= 2'h3;
    HOST.par_rd(w); chk("mode3", w, 16'h0096);
    chk("irq_masked", {15'h0, irq}, 16'h0000);
    {mode_select_hi, mode_select_lo} <= 2'h0;
    position_in <= 16'h3C69;
    HOST.ser(16'h12E7, w); chk("ser_out", w, 16'h3C69);
    rr(ADDR_HOSTBYTE, w); chk("ser_in", w, 16'h00E7);
    rw(ADDR_MASK, 16'h000C);
    loss_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk("lot_on", {15'h0, tracking_loss_n, irq}, 16'h0001);
    loss_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk("lot_off", {15'h0, tracking_loss_n}, 16'h0001);
    rr(ADDR_STATUS, w); chk("st_lot", w & 16'h000C, 16'h0004);
    @(posedge clk);
    chk("irq_clr", {15'h0, irq}, 16'h0000);
    over_threshold_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dos_thr", {15'h0, signal_degraded_n}, 16'h0000);
    {over_threshold_in, mismatch_in} <= 2'h1;
    repeat (3) @(posedge clk);
    chk("dos_mis", {15'h0, signal_degraded_n, irq}, 16'h0001);
    mismatch_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dos_off", {15'h0, signal_degraded_n}, 16'h0001);
    rr(ADDR_STATUS, w); chk("st_dos", w & 16'h000C, 16'h0008);
    rw(ADDR_EXC_FREQ, 16'h0003);
    half(n);
    half(n);
    half(n); chk("exc_half", n[15:0], 16'h0004);
    chk("exc_pair", {15'h0, drive_wave_out ^ drive_wave_out_n}, 16'h0001);
    // Mid-run pin reset must return the registers to their reset values.
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("exc_in_rst", {14'h0, drive_wave_out, drive_wave_out_n},
        16'h0001);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rr(ADDR_EXC_FREQ, w); chk("exc_rst", w, {8'h00, EXC_RESET});
    rr(ADDR_MASK, w); chk("mask_rst", w, {12'h000, MASK_RESET});
    end_sim();
  end
endmodule : testbench
